// File: hw/rx_framer_10b8b_decoder.sv
// What this block does
// [RULE1] Shift each recovered bit in per bit clock.
// [RULE2] Search every bit position for framing pattern.
// [RULE3] Middle select matches either eight-bit comma.
// [RULE4] High select matches only full K28.5 character.
// [RULE5] Comma compare spans eight bits, not seven.
// [RULE6] Disabled framer never moves the character boundary.
// [RULE7] Low-latency mode stretches clock from first detection.
// [RULE8] Stretch at most two bits per character cycle.
// [RULE9] Full-rate clock: aligned within nine characters.
// [RULE10] Half-rate clock: aligned within fourteen characters.
// [RULE11] Middle mode: two matches within 50 bits.
// [RULE12] Multi modes move data, never the clock.
// [RULE13] High mode: four consecutive aligned framing characters.
// [RULE14] Decoder on converts characters to data codes.
// [RULE15] Status 000 data, 001 special, others errors. The code reports K28.5 as 010 and a self-test loop as 100.
// [RULE16] Decoder off passes raw ten-bit characters.
// [RULE17] Bypass needs clock source select at middle.
// [RULE18] Decoder middle uses first special code table.
// [RULE19] Decoder high uses alternate special code table.
// [RULE20] Odd parity generated over each output character.
// [RULE21] Compare received characters with self-test pattern.
// [RULE22] Self-test must not use low-latency framer.
// [RULE23] Character, status and parity leave together.
//
// Register access over APB and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "rx_framer_defines.svh"

module rx_framer_10b8b_decoder (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB register port
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  // Recovered serial bits
  input  wire logic        rx_serial_in,
  // Character output register
  output var  logic [9:0]  rx_data,
  output var  logic [2:0]  rx_char_status,
  output var  logic        rx_parity,
  output var  logic        rx_char_valid,
  output var  logic        rx_char_clk
);

  logic        ser_s1_r;
  logic        ser_s2_r;
  logic [19:0] sh_r;
  logic [`CTRL_WIDTH-1:0] ctrl_r;
  logic [3:0]  cnt_r;
  logic [1:0]  ext_r;
  logic [3:0]  pend_r;
  logic [3:0]  off_r;
  logic [3:0]  last_off_r;
  logic        seen_r;
  logic [5:0]  gap_r;
  logic [2:0]  run_r;
  logic        resync_r;
  logic        framed_r;
  logic [8:0]  lfsr_r;
  logic [15:0] bist_err_r;
  rx_framer_pkg::bist_e bist_st_r;
  logic [31:0] prdata_r;
  logic        pready_r;
  logic        pslverr_r;
  logic [9:0]  rx_data_r;
  logic [2:0]  status_r;
  logic        parity_r;
  logic        valid_r;
  logic        cclk_r;

  // Six-bit sub-block decode: {valid, EDCBA}.
  function automatic logic [5:0] dec6(input logic [5:0] c);
    case (c)
      6'h27, 6'h18: dec6 = 6'h20;
      6'h1D, 6'h22: dec6 = 6'h21;
      6'h2D, 6'h12: dec6 = 6'h22;
      6'h31:        dec6 = 6'h23;
      6'h35, 6'h0A: dec6 = 6'h24;
      6'h29:        dec6 = 6'h25;
      6'h19:        dec6 = 6'h26;
      6'h38, 6'h07: dec6 = 6'h27;
      6'h39, 6'h06: dec6 = 6'h28;
      6'h25:        dec6 = 6'h29;
      6'h15:        dec6 = 6'h2A;
      6'h34:        dec6 = 6'h2B;
      6'h0D:        dec6 = 6'h2C;
      6'h2C:        dec6 = 6'h2D;
      6'h1C:        dec6 = 6'h2E;
      6'h17, 6'h28: dec6 = 6'h2F;
      6'h1B, 6'h24: dec6 = 6'h30;
      6'h23:        dec6 = 6'h31;
      6'h13:        dec6 = 6'h32;
      6'h32:        dec6 = 6'h33;
      6'h0B:        dec6 = 6'h34;
      6'h2A:        dec6 = 6'h35;
      6'h1A:        dec6 = 6'h36;
      6'h3A, 6'h05: dec6 = 6'h37;
      6'h33, 6'h0C: dec6 = 6'h38;
      6'h26:        dec6 = 6'h39;
      6'h16:        dec6 = 6'h3A;
      6'h36, 6'h09: dec6 = 6'h3B;
      6'h0E:        dec6 = 6'h3C;
      6'h0F, 6'h30: dec6 = 6'h3C;
      6'h2E, 6'h11: dec6 = 6'h3D;
      6'h1E, 6'h21: dec6 = 6'h3E;
      6'h2B, 6'h14: dec6 = 6'h3F;
      default:      dec6 = 6'h00;
    endcase
  endfunction

  // Four-bit sub-block decode: {valid, HGF}.
  function automatic logic [3:0] dec4(input logic [3:0] c);
    case (c)
      4'hB, 4'h4: dec4 = 4'h8;
      4'h9:       dec4 = 4'h9;
      4'h5:       dec4 = 4'hA;
      4'hC, 4'h3: dec4 = 4'hB;
      4'hD, 4'h2: dec4 = 4'hC;
      4'hA:       dec4 = 4'hD;
      4'h6:       dec4 = 4'hE;
      4'hE, 4'h1: dec4 = 4'hF;
      4'h7, 4'h8: dec4 = 4'hF;
      default:    dec4 = 4'h0;
    endcase
  endfunction

  // Control fields.
  wire       fen_w   = ctrl_r[`CTRL_FEN_BIT];
  wire [1:0] fmode_w = ctrl_r[`CTRL_FMODE_LSB +: 2];
  wire [1:0] fchar_w = ctrl_r[`CTRL_FCHAR_LSB +: 2];
  wire [1:0] dec_w   = ctrl_r[`CTRL_DEC_LSB +: 2];
  wire       rate_w  = ctrl_r[`CTRL_RATE_BIT];
  wire       bist_w  = ctrl_r[`CTRL_BIST_BIT];
  wire       ll_w    = (fmode_w == rx_framer_pkg::LVL_LOW);

  // Pattern compare on the newest ten bits.
  wire comma_w = (sh_r[9:2] == `COMMA_POS) ||
                 (sh_r[9:2] == `COMMA_NEG);                    // [RULE5]
  wire k285_w  = (sh_r[9:0] == `K285_NEG_RD) ||
                 (sh_r[9:0] == `K285_POS_RD);
  wire pat_w   = (fchar_w == rx_framer_pkg::LVL_MID)  ? comma_w : // [RULE3]
                 (fchar_w == rx_framer_pkg::LVL_HIGH) ? k285_w  : // [RULE4]
                 1'b0;
  wire busy_w  = (pend_r != 4'h0) || (ext_r != 2'h0);
  wire match_w = fen_w && pat_w && !busy_w;                    // [RULE2] [RULE6]

  // Boundary timing and alignment arithmetic.
  wire       bnd_w     = (cnt_r == (`CHAR_LAST_BIT + {2'h0, ext_r}));
  wire [3:0] cnt_nxt   = bnd_w ? 4'h0 : cnt_r + 4'h1;
  wire [3:0] det_off_w = `CHAR_LAST_BIT - cnt_r;
  wire [3:0] det_sh_w  = (cnt_r == `CHAR_LAST_BIT) ? 4'h0 : cnt_r + 4'h1;
  wire [1:0] ext_nxt   = (pend_r > {2'h0, `MAX_STRETCH_BITS}) ?
                         `MAX_STRETCH_BITS : pend_r[1:0];      // [RULE8]
  wire       same_w    = seen_r && (det_off_w == last_off_r);
  wire [2:0] run_nxt   = (same_w && gap_r == 6'h09) ?
                         ((run_r == 3'h7) ? run_r : run_r + 3'h1) : 3'h1;
  wire adopt_mid_w = match_w && (fmode_w == rx_framer_pkg::LVL_MID) &&
                     same_w && (gap_r < `MULTI_MAX_GAP);       // [RULE11]
  wire adopt_alt_w = match_w && (fmode_w == rx_framer_pkg::LVL_HIGH) &&
                     (run_nxt >= `ALT_RUN_NEEDED);             // [RULE13]
  wire adopt_w     = adopt_mid_w || adopt_alt_w;

  // Framed character and decode.
  wire [9:0] char_w  = sh_r[off_r +: 10];
  wire [5:0] d6_w    = dec6(char_w[9:4]);
  // A K28 of positive disparity carries its last four bits inverted.
  wire [3:0] fghj_w  = (char_w[9:4] == 6'h30) ? ~char_w[3:0] : char_w[3:0];
  wire [3:0] d4_w    = dec4(fghj_w);
  wire [7:0] byte_w  = {d4_w[2:0], d6_w[4:0]};                 // [RULE14]
  wire       k28_w   = (char_w[9:4] == 6'h0F) || (char_w[9:4] == 6'h30);
  wire       a7_w    = (char_w[3:0] == 4'h7) || (char_w[3:0] == 4'h8);
  wire       kx7_w   = a7_w && ((d6_w[4:0] == 5'h17) ||
                       (d6_w[4:0] == 5'h1B) || (d6_w[4:0] == 5'h1D) ||
                       (d6_w[4:0] == 5'h1E));
  wire       spec_w  = k28_w || kx7_w;
  wire       inv_w   = !d6_w[5] || !d4_w[3];
  wire       frm_w   = (char_w == `K285_NEG_RD) || (char_w == `K285_POS_RD);
  wire [7:0] alt_w   = {byte_w[4:0], byte_w[7:5]};
  wire [7:0] code_w  = (spec_w && dec_w == rx_framer_pkg::LVL_HIGH) ?
                       alt_w : byte_w;                         // [RULE18] [RULE19]
  wire       bypass_w = (dec_w == rx_framer_pkg::LVL_LOW);
  wire [9:0] out_w   = bypass_w ? char_w : {2'h0, code_w};     // [RULE16]
  wire [2:0] dst_w   = resync_r ? `ST_RESYNC :
                       bypass_w ? `ST_DATA :
                       inv_w    ? `ST_INVALID :
                       frm_w    ? `ST_FRAMING :
                       spec_w   ? `ST_SPECIAL : `ST_DATA;      // [RULE15]

  // Self-test checker.
  wire [8:0] lfsr_nxt  = {lfsr_r[7:0], lfsr_r[8] ^ lfsr_r[4]};
  wire       d00_w     = !spec_w && !inv_w && (byte_w == 8'h00);
  wire       bmiss_w   = (byte_w != lfsr_r[7:0]) || spec_w;
  wire       bloop_w   = (lfsr_nxt == `BIST_SEED);
  wire       brun_w    = (bist_st_r == rx_framer_pkg::BIST_RUN);
  wire [2:0] bst_w     = !brun_w ? `ST_DATA :
                         bloop_w ? `ST_BIST_LOOP :
                         bmiss_w ? `ST_BIST_ERR : `ST_DATA;    // [RULE21]
  wire [2:0] st_out_w  = bist_w ? bst_w : dst_w;

  // APB decode.
  wire sel_ctrl_w = (paddr == `CTRL_OFFSET);
  wire sel_stat_w = (paddr == `STATUS_OFFSET);
  wire sel_berr_w = (paddr == `BIST_ERR_OFFSET);
  wire mapped_w   = sel_ctrl_w || sel_stat_w || sel_berr_w;
  wire setup_w    = psel && !penable;
  wire wr_w       = psel && penable && pwrite && pready_r;
  wire [31:0] rd_w = sel_ctrl_w ? {23'h0, ctrl_r} :
                     sel_stat_w ? {25'h0, brun_w, busy_w, framed_r, off_r}
                                : sel_berr_w ? {16'h0, bist_err_r} : 32'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ser_s1_r <= 1'b0;
      ser_s2_r <= 1'b0;
      sh_r     <= 20'h00000;
    end else begin
      ser_s1_r <= rx_serial_in;
      ser_s2_r <= ser_s1_r;
      sh_r     <= {sh_r[18:0], ser_s2_r};                      // [RULE1]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r    <= `CTRL_RESET;
      prdata_r  <= 32'h00000000;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r  <= setup_w;
      pslverr_r <= setup_w && !mapped_w;
      if (setup_w) begin
        prdata_r <= rd_w;
      end
      if (wr_w && sel_ctrl_w) begin
        ctrl_r <= pwdata[`CTRL_WIDTH-1:0];
      end
    end
  end

  // Character clock, low-latency stretching and data offset.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r    <= 4'h0;
      ext_r    <= 2'h0;
      pend_r   <= 4'h0;
      off_r    <= 4'h0;
      resync_r <= 1'b0;
      framed_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      if (bnd_w) begin
        ext_r    <= ext_nxt;                                   // [RULE8]
        pend_r   <= pend_r - {2'h0, ext_nxt};
        resync_r <= 1'b0;
      end else if (match_w && ll_w) begin
        pend_r <= det_sh_w;                                    // [RULE7]
        off_r  <= 4'h0;
      end
      if (match_w && !ll_w && adopt_w) begin
        off_r    <= det_off_w;                                 // [RULE12]
        resync_r <= (det_off_w != off_r);
        framed_r <= 1'b1;
      end else if (match_w && ll_w) begin
        framed_r <= 1'b1;
      end
    end
  end

  // Multi-character framer history.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_off_r <= 4'h0;
      seen_r     <= 1'b0;
      gap_r      <= 6'h3F;
      run_r      <= 3'h0;
    end else if (match_w) begin
      last_off_r <= det_off_w;
      seen_r     <= 1'b1;
      gap_r      <= 6'h00;
      run_r      <= run_nxt;                                   // [RULE13]
    end else begin
      gap_r <= (gap_r == 6'h3F) ? gap_r : gap_r + 6'h01;
    end
  end

  // Output register: one character with status and parity.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_data_r <= 10'h000;
      status_r  <= `ST_DATA;
      parity_r  <= 1'b1;
      valid_r   <= 1'b0;
      cclk_r    <= 1'b1;
    end else begin
      valid_r <= bnd_w;
      if (bnd_w) begin
        rx_data_r <= out_w;                                    // [RULE23]
        status_r  <= st_out_w;
        parity_r  <= ~^out_w;                                  // [RULE20]
      end
      if (rate_w) begin
        cclk_r <= bnd_w ? ~cclk_r : cclk_r;                    // [RULE10]
      end else begin
        cclk_r <= (cnt_nxt < 4'h5);                            // [RULE9]
      end
    end
  end

  // Self-test pattern tracking.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lfsr_r     <= `BIST_SEED;
      bist_st_r  <= rx_framer_pkg::BIST_IDLE;
      bist_err_r <= 16'h0000;
    end else if (!bist_w) begin
      lfsr_r    <= `BIST_SEED;
      bist_st_r <= rx_framer_pkg::BIST_IDLE;
    end else if (bnd_w) begin
      case (bist_st_r)
        rx_framer_pkg::BIST_IDLE: begin
          if (d00_w) begin
            bist_st_r <= rx_framer_pkg::BIST_RUN;
            lfsr_r    <= lfsr_nxt;
          end
        end
        rx_framer_pkg::BIST_RUN: begin
          lfsr_r <= lfsr_nxt;
          if (bmiss_w && bist_err_r != 16'hFFFF) begin
            bist_err_r <= bist_err_r + 16'h0001;               // [RULE21]
          end
          if (bloop_w) begin
            bist_st_r <= rx_framer_pkg::BIST_IDLE;
          end
        end
        default: bist_st_r <= rx_framer_pkg::BIST_IDLE;
      endcase
    end
  end

  assign prdata         = prdata_r;
  assign pready         = pready_r;
  assign pslverr        = pslverr_r;
  assign rx_data        = rx_data_r;
  assign rx_char_status = status_r;
  assign rx_parity      = parity_r;
  assign rx_char_valid  = valid_r;
  assign rx_char_clk    = cclk_r;

  // Checking helpers: cycles between output characters.
  logic [4:0] len_r;
  logic       started_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      len_r     <= 5'h00;
      started_r <= 1'b0;
    end else begin
      len_r     <= valid_r ? 5'h01 : len_r + 5'h01;
      started_r <= started_r || valid_r;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_hold_disabled;
    !fen_w |=> $stable(off_r) && (pend_r <= $past(pend_r));
  endproperty
  a_hold_disabled: assert property (p_hold_disabled) // [RULE6]
    else $error("boundary moved while framer disabled");

  property p_stretch_limit;
    (valid_r && started_r) |-> (len_r <= 5'h0C);
  endproperty
  a_stretch_limit: assert property (p_stretch_limit) // [RULE8]
    else $error("character cycle stretched beyond two bits");

  property p_multi_no_hop;
    (valid_r && started_r && $past(ext_r) == 2'h0) |-> (len_r == 5'h0A);
  endproperty
  a_multi_no_hop: assert property (p_multi_no_hop) // [RULE12]
    else $error("character clock phase moved without stretch");

  property p_ll_latency;
    (match_w && ll_w) |-> ##[1:90] !busy_w;
  endproperty
  a_ll_latency: assert property (p_ll_latency) // [RULE9]
    else $error("low-latency alignment too slow");

  property p_mid_match;
    (fchar_w == rx_framer_pkg::LVL_MID && pat_w) |->
      (sh_r[9:2] == `COMMA_POS || sh_r[9:2] == `COMMA_NEG);
  endproperty
  a_mid_match: assert property (p_mid_match) // [RULE3]
    else $error("comma match on wrong pattern");

  property p_k285_match;
    (fchar_w == rx_framer_pkg::LVL_HIGH && pat_w) |->
      (sh_r[9:0] == `K285_NEG_RD || sh_r[9:0] == `K285_POS_RD);
  endproperty
  a_k285_match: assert property (p_k285_match) // [RULE4]
    else $error("full K28.5 match on wrong pattern");

  property p_alt_four;
    (fen_w && fmode_w == rx_framer_pkg::LVL_HIGH && !ll_w &&
     off_r != $past(off_r)) |-> ($past(run_r) >= 3'h3);
  endproperty
  a_alt_four: assert property (p_alt_four) // [RULE13]
    else $error("alternate framer moved before four characters");

  property p_parity;
    valid_r |-> (^{rx_data_r, parity_r} == 1'b1);
  endproperty
  a_parity: assert property (p_parity) // [RULE20]
    else $error("output parity is not odd");

  property p_bypass_raw;
    (bnd_w && bypass_w) |=> (rx_data_r == $past(char_w));
  endproperty
  a_bypass_raw: assert property (p_bypass_raw) // [RULE16]
    else $error("bypassed character altered");

  property p_data_status;
    (bnd_w && !bist_w && !bypass_w && !resync_r && !inv_w && !spec_w) |=>
      (status_r == `ST_DATA) && (rx_data_r[7:0] == $past(byte_w));
  endproperty
  a_data_status: assert property (p_data_status) // [RULE15]
    else $error("data character not reported as data");

  c_ll_align: cover property (match_w && ll_w && det_sh_w != 4'h0);
  c_mid_adopt: cover property (adopt_mid_w);
  c_alt_adopt: cover property (adopt_alt_w);
  c_special: cover property (bnd_w && spec_w && !bypass_w);

endmodule // rx_framer_10b8b_decoder
`default_nettype wire

// File: hw/rx_framer_defines.svh
`ifndef RX_FRAMER_DEFINES_SVH
`define RX_FRAMER_DEFINES_SVH

// Register byte offsets.
`define CTRL_OFFSET      12'h000
`define STATUS_OFFSET    12'h004
`define BIST_ERR_OFFSET  12'h008

// Control register fields.
`define CTRL_FEN_BIT     0
`define CTRL_FMODE_LSB   1
`define CTRL_FCHAR_LSB   3
`define CTRL_DEC_LSB     5
`define CTRL_RATE_BIT    7
`define CTRL_BIST_BIT    8
`define CTRL_WIDTH       9
`define CTRL_RESET       9'h02B

// Framing patterns, first received bit on the left.
`define COMMA_POS        8'h3E
`define COMMA_NEG        8'hC1
`define K285_NEG_RD      10'h0FA
`define K285_POS_RD      10'h305

// Framer timing in bit periods and characters.
`define CHAR_LAST_BIT    4'h9
`define MULTI_SPAN_BITS  6'h32
`define MULTI_MAX_GAP    (`MULTI_SPAN_BITS - 6'h0A)
`define ALT_RUN_NEEDED   3'h4
`define MAX_STRETCH_BITS 2'h2

// Receive status codes.
`define ST_DATA          3'h0
`define ST_SPECIAL       3'h1
`define ST_FRAMING       3'h2
`define ST_RESYNC        3'h3
`define ST_BIST_LOOP     3'h4
`define ST_BIST_ERR      3'h5
`define ST_INVALID       3'h7

// Self-test sequence start value.
`define BIST_SEED        9'h1FF

`endif

// File: hw/rx_framer_pkg.sv
package rx_framer_pkg;

  // Three-level select as held in the control register.
  typedef enum logic [1:0] {
    LVL_LOW,
    LVL_MID,
    LVL_HIGH
  } level_e;

  // Receive self-test checker state.
  typedef enum logic {
    BIST_IDLE,
    BIST_RUN
  } bist_e;

endpackage

// File: dv/serial_char_sender.sv
`timescale 1ns/100ps
`default_nettype none
// Far-end transmitter: sends ten-bit characters, bit 9 first.
module serial_char_sender (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Character feed
  input  wire logic [9:0] tx_char,
  input  wire logic       slip_req,
  output var  logic       tx_load,
  // Serial line
  output var  logic       tx_serial
);
  logic [9:0] sh_r;
  logic [3:0] cnt_r;
  logic       slip_r;

  // A slip sends one extra bit and moves all later boundaries.
  assign tx_load   = (cnt_r == 4'h9 && !slip_r) || cnt_r == 4'hA;
  assign tx_serial = sh_r[9];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sh_r   <= 10'h155;
      cnt_r  <= 4'h0;
      slip_r <= 1'b0;
    end else begin
      if (slip_req) begin
        slip_r <= 1'b1;
      end else if (cnt_r == 4'hA) begin
        slip_r <= 1'b0;
      end
      if (tx_load) begin
        sh_r  <= tx_char;
        cnt_r <= 4'h0;
      end else begin
        sh_r  <= {sh_r[8:0], 1'b0};
        cnt_r <= cnt_r + 4'h1;
      end
    end
  end
endmodule // serial_char_sender
`default_nettype wire

// File: dv/rx_framer_10b8b_decoder_test.sv
`timescale 1ns/100ps
`default_nettype none
`include "rx_framer_defines.svh"
module rx_framer_10b8b_decoder_test;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic        ser, tx_load, slip_req, rx_parity, rx_char_valid;
  logic        rx_char_clk, erv, hit, byp, alt, gap_on;
  logic [9:0]  rx_data, tx_char;
  logic [2:0]  rx_char_status;
  logic [9:0]  pc [8];
  logic [9:0]  ed [8];
  logic [2:0]  es [8];
  int          plen, pi, gap, gap_max, n_errors, tests_run;

  rx_framer_10b8b_decoder u_rx_framer_10b8b_decoder (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_serial_in(ser),
    .rx_data(rx_data), .rx_char_status(rx_char_status),
    .rx_parity(rx_parity), .rx_char_valid(rx_char_valid),
    .rx_char_clk(rx_char_clk));

  serial_char_sender u_serial_char_sender (
    .pclk(pclk), .presetn(presetn), .tx_char(tx_char),
    .slip_req(slip_req), .tx_load(tx_load), .tx_serial(ser));

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // Feed the repeating pattern to the far end.
  always @(posedge pclk) begin
    if (tx_load) begin
      tx_char <= pc[pi];
      pi <= (pi + 1 >= plen) ? 0 : pi + 1;
    end
  end

  // Spacing of characters; the clock may stretch only in low latency.
  always @(negedge pclk) begin
    if (rx_char_valid === 1'b1) begin
      if (gap_on) chk("gap", 32'h1, 32'(gap >= 10 && gap <= gap_max));
      gap <= 1;
    end else begin
      gap <= gap + 1;
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, g);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic end_sim;
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(negedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      @(negedge pclk);
      n++;
    end
    if (n == 20) chk("pready", 32'h1, 32'h0);
    rdv = prdata;
    erv = pslverr;
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic slip;
    slip_req <= 1'b1;
    @(posedge pclk);
    slip_req <= 1'b0;
  endtask

  task automatic put(input int i, input logic [9:0] c,
                     input logic [7:0] b, input logic [2:0] s);
    pc[i] = c;
    es[i] = byp ? `ST_DATA : s;
    if (byp) ed[i] = c;
    else if (s == `ST_INVALID) ed[i] = 10'h3FF;
    else if (alt && s != `ST_DATA) ed[i] = {2'h0, b[4:0], b[7:5]};
    else ed[i] = {2'h0, b};
  endtask

  task automatic pat(input string p);
    for (int i = 0; i < p.len(); i++) begin
      case (p[i])
        "M": put(i, 10'h0F4, 8'h1C, `ST_SPECIAL);
        "K": put(i, 10'h0FA, 8'hBC, `ST_FRAMING);
        "P": put(i, 10'h305, 8'hBC, `ST_FRAMING);
        "A": put(i, 10'h2AA, 8'hB5, `ST_DATA);
        "B": put(i, 10'h155, 8'h4A, `ST_DATA);
        "Q": put(i, 10'h0FC, 8'h00, `ST_INVALID);
        default: put(i, 10'h000, 8'h00, `ST_INVALID);
      endcase
    end
    plen = p.len();
  endtask

  task automatic recv(output logic [9:0] d, output logic [2:0] s,
                      output logic p);
    int n;
    n = 0;
    @(negedge pclk);
    while (rx_char_valid !== 1'b1 && n < 40) begin
      @(negedge pclk);
      n++;
    end
    if (n == 40) chk("char_valid", 32'h1, 32'h0);
    d = rx_data;
    s = rx_char_status;
    p = rx_parity;
  endtask

  // Skip old characters, look for the marker, then check two passes.
  task automatic stream(input int len, input int maxc, input logic ex);
    logic [9:0] d;
    logic [2:0] s;
    logic       p;
    int         j;
    hit = 1'b0;
    for (int i = 0; i < maxc + 6 && !hit; i++) begin
      recv(d, s, p);
      if (i >= 6) hit = (d === ed[0] && s === es[0]);
    end
    chk("lock", 32'(ex), 32'(hit));
    for (int k = 1; hit && k < 2 * len; k++) begin
      recv(d, s, p);
      j = k % len;
      chk("status", 32'(es[j]), 32'(s));
      if (ed[j] !== 10'h3FF) begin
        chk("data", 32'(ed[j]), 32'(d));
        chk("parity", 32'(~^ed[j]), 32'(p));
      end
    end
  endtask

  task automatic t_regs;
    apb(1'b0, `CTRL_OFFSET, 32'h0);
    chk("ctrl_reset", 32'h0000_002B, rdv);
    apb(1'b1, 12'h00C, 32'hFFFF_FFFF);
    chk("unmapped_wr_err", 32'h1, 32'(erv));
    apb(1'b0, 12'h00C, 32'h0);
    chk("unmapped_rd", 32'h0, rdv);
    chk("unmapped_rd_err", 32'h1, 32'(erv));
    apb(1'b0, `STATUS_OFFSET, 32'h0);
    chk("status_err", 32'h0, 32'(erv));
    apb(1'b1, `CTRL_OFFSET, 32'hFFFF_FE2B);
    apb(1'b0, `CTRL_OFFSET, 32'h0);
    chk("ctrl_mask", 32'h0000_002B, rdv);
  endtask

  task automatic t_decode;
    pat("MKKABI");
    stream(6, 30, 1'b1);
    gap_on = 1'b1;
    alt = 1'b1;
    pat("MKKAB");
    apb(1'b1, `CTRL_OFFSET, 32'h0000_004B);
    stream(5, 30, 1'b1);
    alt = 1'b0;
    byp = 1'b1;
    pat("MKAB");
    apb(1'b1, `CTRL_OFFSET, 32'h0000_000B);
    stream(4, 30, 1'b1);
    byp = 1'b0;
  endtask

  task automatic t_frame;
    apb(1'b1, `CTRL_OFFSET, 32'h0000_002A);
    slip();
    pat("MKKKKA");
    stream(6, 30, 1'b0);
    apb(1'b1, `CTRL_OFFSET, 32'h0000_0035);
    pat("MKPK");
    stream(4, 30, 1'b0);
    pat("MKPKPA");
    stream(6, 30, 1'b1);
    apb(1'b1, `CTRL_OFFSET, 32'h0000_002B);
    slip();
    pat("MQQAB");
    stream(5, 30, 1'b0);
    pat("MKABA");
    stream(5, 30, 1'b0);
    pat("MPAB");
    stream(4, 30, 1'b1);
  endtask

  task automatic t_lowlat;
    gap_max = 12;
    apb(1'b1, `CTRL_OFFSET, 32'h0000_0029);
    slip();
    stream(4, 15, 1'b1);
    apb(1'b1, `CTRL_OFFSET, 32'h0000_00A9);
    slip();
    stream(4, 20, 1'b1);
  endtask

  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    slip_req = 1'b0;
    tx_char = 10'h155;
    presetn = 1'b0;
    {byp, alt, gap_on} = 3'h0;
    pi = 0;
    gap = 0;
    n_errors = 0;
    tests_run = 0;
    gap_max = 10;
    pat("MKKABI");
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_decode();
    t_frame();
    t_lowlat();
    end_sim();
  end

  initial begin
    repeat (40000) @(posedge pclk);
    n_errors++;
    end_sim();
  end
endmodule // rx_framer_10b8b_decoder_test
`default_nettype wire
